// >>> pors_consts.vh
// Purpose: Shared constants for the power-on acknowledge and reset-domain block.
// Assumes: A 100 MHz core clock and a 32768 Hz low-frequency tick derived from it.
// Notes: Offsets are APB byte addresses; every register is one aligned 32-bit word.
`ifndef PORS_CONSTS_VH
`define PORS_CONSTS_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define PORS_OFS_DEVICE_CONTROL 8'h00
`define PORS_OFS_CONFIG 8'h04
`define PORS_OFS_OFF_RESET_LEVEL 8'h08
`define PORS_OFS_INT_STATUS 8'h0c
`define PORS_OFS_INT_MASK 8'h10
`define PORS_OFS_BOOT_STATUS 8'h14
`define PORS_OFS_SWOFF_CAUSE 8'h18
`define PORS_OFS_PGOOD_MASK 8'h1c
`define PORS_OFS_STATE 8'h20
`define PORS_OFS_RES_BASE 8'h40
`define PORS_OFS_RES_LAST 8'h5c

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PORS_DEVCTL_ON 0
`define PORS_CFG_REG_ACK 0
`define PORS_CFG_AUTO_ON 1
`define PORS_CFG_INT_SLEEP_MASK 2
`define PORS_OFFRST_ACK_FALL 0
`define PORS_OFFRST_TIMEOUT 1
`define PORS_CAUSE_ACK_FALL 0
`define PORS_CAUSE_TIMEOUT 1
`define PORS_I_END 15
`define PORS_I_BRANCH 14

// ----------------------------------------------------------------------------
// Reset values, reset levels and sequence layout
// ----------------------------------------------------------------------------
`define PORS_CONFIG_RST 3'h6
`define PORS_OFF_RESET_LEVEL_RST 2'h3
`define PORS_INT_MASK_RST 8'h00
`define PORS_LEVEL_POR 2'h0
`define PORS_LEVEL_HW 2'h1
`define PORS_LEVEL_SWO 2'h2
`define PORS_BANK0_BASE 7'h00
`define PORS_BANK1_BASE 7'h30
`define PORS_DOWN_OFS 7'h18

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PORS_CLK_HZ 100000000
`define PORS_LF_HZ 32768
`define PORS_HOLD_S 8
`define PORS_LF_DIV (`PORS_CLK_HZ / `PORS_LF_HZ)
`define PORS_HOLD_TICKS (`PORS_HOLD_S * `PORS_LF_HZ)

`endif

// >>> pors_seq_rom.v
// Purpose: Stored power sequence image, one 16-bit instruction per address.
// Assumes: Bank 0 spans 0x00..0x2f and bank 1 spans 0x30..0x5f.
// Notes: Instruction: bit15 end, bit14 branch on boot level, [10:8] target, [7:0] data.
`timescale 1ns/10ps
`default_nettype none

module pors_seq_rom
(
    input wire [6:0] addr,
    output reg [15:0] instr
);

    // ------------------------------------------------------------------------
    // Image contents
    // ------------------------------------------------------------------------
    // Unprogrammed words read as end so a stray jump cannot run away.
    always @*
    begin
        case (addr)
            7'h00: instr = 16'h0001;
            7'h01: instr = 16'h0411;
            7'h02: instr = 16'h4005;
            7'h03: instr = 16'h0121;
            7'h04: instr = 16'h8000;
            7'h05: instr = 16'h0122;
            7'h06: instr = 16'h8000;
            7'h18: instr = 16'h0400;
            7'h19: instr = 16'h0000;
            7'h1a: instr = 16'h8000;
            7'h30: instr = 16'h0003;
            7'h31: instr = 16'h0433;
            7'h32: instr = 16'h4005;
            7'h33: instr = 16'h0141;
            7'h34: instr = 16'h8000;
            7'h35: instr = 16'h0142;
            7'h36: instr = 16'h8000;
            7'h48: instr = 16'h0400;
            7'h49: instr = 16'h0000;
            7'h4a: instr = 16'h8000;
            default: instr = 16'h8000;
        endcase
    end

endmodule // pors_seq_rom
`default_nettype wire

// >>> pors_top.v
// Purpose: Power-on acknowledge, boot select, stored sequencing and reset domains.
// Assumes: All pins are synchronous to clk; resetn is the global power-on reset.
// Notes: APB slave with zero wait states; regulator analog behaviour is outside.
//
// What this block does
// - System reset held until power-up sequence completes.
// - ON request starts sequence; reset released in ACTIVE.
// - Hold mode: shut down unless acknowledged within 8s.
// - Hold pin falling edge is an OFF request.
// - Auto mode sets device-on bit at sequence end.
// - Non-auto register mode follows device-on bit like pin.
// - Boot level selects image bank and sequence selector.
// - Boot level latched at power-up end, readable.
// - Sequencer branches on boot level without altering image.
// - Sequence is an ordered series of register writes.
// - Host may overwrite settings after sequence completes.
// - Power-on reset clears all three domains.
// - Power-on domain registers survive lower resets.
// - Hardware-reset OFF request runs down sequence to OFF.
// - Hardware reset clears hardware and switch-off domains.
// - Other OFF requests clear only switch-off domain.
// - Hardware domain holds config, interrupts, low resources.
// - Switch-off domain holds device control, high resources.
// - Reset levels coded 0 power-on, 1 hardware, 2 switch-off.
// - Interrupt line low while unmasked interrupt pending.
// - Line masked in sleep by config; sources individually masked.
`timescale 1ns/10ps
`default_nettype none
`include "pors_consts.vh"

module pors_top
#(
    parameter LF_DIV = `PORS_LF_DIV,
    parameter HOLD_TICKS = `PORS_HOLD_TICKS
)
(
    input wire clk,
    input wire resetn,
    input wire [7:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire on_request,
    input wire hold_on_pin,
    input wire boot_sel,
    input wire sleep_req,
    input wire [7:0] irq_src,
    output reg reset_out,
    output reg int_n,
    output reg [1:0] reset_level,
    output reg hw_reset_pulse,
    output reg swo_reset_pulse,
    output reg [2:0] power_state
);

    // ------------------------------------------------------------------------
    // State codes
    // ------------------------------------------------------------------------
    localparam [2:0] ST_OFF = 3'h0;
    localparam [2:0] ST_SEQ_UP = 3'h1;
    localparam [2:0] ST_ACTIVE = 3'h2;
    localparam [2:0] ST_SLEEP = 3'h3;
    localparam [2:0] ST_SEQ_DOWN = 3'h4;

    reg [2:0] state_q, config_q;
    reg [6:0] pc_q;
    reg seq_bank_q, boot_status_q, device_on_bit_q, lf_tick_q, ack_seen_q, ack_prev_q, off_hw_q;
    reg [1:0] off_reset_level_config_q, switchoff_cause_status_q;
    reg [7:0] int_status_q, int_mask_q, pgood_mask_q;
    reg [7:0] res_hw_q [0:3], res_swo_q [0:3];
    reg [11:0] lf_cnt_q;
    reg [19:0] hold_cnt_q;
    wire [15:0] instr;
    wire ack_level, ack_fall, hold_expired, off_req, in_run;
    wire setup_ph, wr_en, addr_ok, res_hit, seq_wr;
    wire [2:0] res_idx;
    wire [6:0] bank_base;
    integer i, j;

    function [6:0] base_of;
        input bank;
        base_of = bank ? `PORS_BANK1_BASE : `PORS_BANK0_BASE;
    endfunction

    pors_seq_rom u_rom
    (
        .addr(pc_q),
        .instr(instr)
    );

    // ------------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------------
    assign setup_ph = psel & ~penable;
    assign wr_en = psel & penable & pwrite;
    assign res_hit = (paddr >= `PORS_OFS_RES_BASE) && (paddr <= `PORS_OFS_RES_LAST);
    assign res_idx = paddr[4:2];
    assign addr_ok = (paddr[1:0] == 2'h0) && (res_hit || (paddr <= `PORS_OFS_STATE));
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;

    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            prdata <= 32'h00000000;
        else if (setup_ph)
        begin
            prdata <= 32'h00000000;
            case (paddr)
                `PORS_OFS_DEVICE_CONTROL: prdata[0] <= device_on_bit_q;
                `PORS_OFS_CONFIG: prdata[2:0] <= config_q;
                `PORS_OFS_OFF_RESET_LEVEL: prdata[1:0] <= off_reset_level_config_q;
                `PORS_OFS_INT_STATUS: prdata[7:0] <= int_status_q;
                `PORS_OFS_INT_MASK: prdata[7:0] <= int_mask_q;
                `PORS_OFS_BOOT_STATUS: prdata[0] <= boot_status_q;
                `PORS_OFS_SWOFF_CAUSE: prdata[1:0] <= switchoff_cause_status_q;
                `PORS_OFS_PGOOD_MASK: prdata[7:0] <= pgood_mask_q;
                `PORS_OFS_STATE: prdata[4:0] <= {reset_level, power_state};
                default: prdata[7:0] <= !res_hit ? 8'h00
                    : res_idx[2] ? res_swo_q[res_idx[1:0]] : res_hw_q[res_idx[1:0]];
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Low-frequency tick and acknowledge window
    // ------------------------------------------------------------------------
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            lf_cnt_q <= 12'h000;
            lf_tick_q <= 1'b0;
        end
        else
        begin
            lf_tick_q <= (lf_cnt_q == LF_DIV[11:0] - 12'h001);
            if (lf_cnt_q == LF_DIV[11:0] - 12'h001)
                lf_cnt_q <= 12'h000;
            else
                lf_cnt_q <= lf_cnt_q + 12'h001;
        end
    end
    assign ack_level = config_q[`PORS_CFG_REG_ACK] ? device_on_bit_q : hold_on_pin;
    assign ack_fall = ack_prev_q & ~ack_level;
    assign in_run = (state_q == ST_ACTIVE) || (state_q == ST_SLEEP);
    assign hold_expired = in_run && !ack_seen_q && (hold_cnt_q >= HOLD_TICKS[19:0]);
    assign off_req = in_run && (ack_fall || hold_expired);
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            hold_cnt_q <= 20'h00000;
            ack_seen_q <= 1'b0;
            ack_prev_q <= 1'b0;
        end
        else
        begin
            ack_prev_q <= in_run & ack_level;
            if (!in_run)
            begin
                hold_cnt_q <= 20'h00000;
                ack_seen_q <= 1'b0;
            end
            else if (ack_level)
                ack_seen_q <= 1'b1;
            else if (!ack_seen_q && lf_tick_q && !hold_expired)
                hold_cnt_q <= hold_cnt_q + 20'h00001;
        end
    end

    // ------------------------------------------------------------------------
    // Power state machine and sequencer
    // ------------------------------------------------------------------------
    assign bank_base = base_of(seq_bank_q);
    assign seq_wr = ((state_q == ST_SEQ_UP) || (state_q == ST_SEQ_DOWN))
                    && !instr[`PORS_I_END] && !instr[`PORS_I_BRANCH];
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q <= ST_OFF;
            pc_q <= 7'h00;
            seq_bank_q <= 1'b0;
            boot_status_q <= 1'b0;
            off_hw_q <= 1'b0;
            reset_level <= `PORS_LEVEL_POR;
            hw_reset_pulse <= 1'b0;
            swo_reset_pulse <= 1'b0;
        end
        else
        begin
            hw_reset_pulse <= 1'b0;
            swo_reset_pulse <= 1'b0;
            case (state_q)
                ST_OFF:
                begin
                    if (on_request)
                    begin
                        seq_bank_q <= boot_sel;
                        pc_q <= base_of(boot_sel);
                        state_q <= ST_SEQ_UP;
                    end
                end
                ST_SEQ_UP, ST_SEQ_DOWN:
                begin
                    if (instr[`PORS_I_END])
                    begin
                        if (state_q == ST_SEQ_UP)
                        begin
                            boot_status_q <= boot_sel;
                            state_q <= ST_ACTIVE;
                        end
                        else
                        begin
                            state_q <= ST_OFF;
                            hw_reset_pulse <= off_hw_q;
                            swo_reset_pulse <= 1'b1;
                            reset_level <= off_hw_q ? `PORS_LEVEL_HW : `PORS_LEVEL_SWO;
                        end
                    end
                    else if (instr[`PORS_I_BRANCH] && boot_sel)
                        pc_q <= bank_base + instr[6:0];
                    else
                        pc_q <= pc_q + 7'h01;
                end
                ST_ACTIVE, ST_SLEEP:
                begin
                    if (off_req)
                    begin
                        off_hw_q <= ack_fall ? off_reset_level_config_q[`PORS_OFFRST_ACK_FALL]
                                             : off_reset_level_config_q[`PORS_OFFRST_TIMEOUT];
                        pc_q <= bank_base + `PORS_DOWN_OFS;
                        state_q <= ST_SEQ_DOWN;
                    end
                    else if (state_q == ST_ACTIVE && sleep_req)
                        state_q <= ST_SLEEP;
                    else if (state_q == ST_SLEEP && !sleep_req)
                        state_q <= ST_ACTIVE;
                end
                default: state_q <= ST_OFF;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Power-on domain: cause status and power-good mask
    // ------------------------------------------------------------------------
    // Only resetn reaches these, so the cause of the last switch-off survives.
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            switchoff_cause_status_q <= 2'h0;
            pgood_mask_q <= 8'h00;
        end
        else
        begin
            switchoff_cause_status_q <= (switchoff_cause_status_q
                & ~((wr_en && paddr == `PORS_OFS_SWOFF_CAUSE) ? pwdata[1:0] : 2'h0))
                | {off_req & hold_expired, off_req & ack_fall};
            if (wr_en && paddr == `PORS_OFS_PGOOD_MASK)
                pgood_mask_q <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------------------
    // Hardware domain: config, interrupts, resources 0..3
    // ------------------------------------------------------------------------
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            config_q <= `PORS_CONFIG_RST;
            off_reset_level_config_q <= `PORS_OFF_RESET_LEVEL_RST;
            int_status_q <= 8'h00;
            int_mask_q <= `PORS_INT_MASK_RST;
            for (i = 0; i < 4; i = i + 1)
                res_hw_q[i] <= 8'h00;
        end
        else if (hw_reset_pulse)
        begin
            config_q <= `PORS_CONFIG_RST;
            off_reset_level_config_q <= `PORS_OFF_RESET_LEVEL_RST;
            int_status_q <= 8'h00;
            int_mask_q <= `PORS_INT_MASK_RST;
            for (i = 0; i < 4; i = i + 1)
                res_hw_q[i] <= 8'h00;
        end
        else
        begin
            // A new event in the clearing cycle wins over the clear.
            int_status_q <= (int_status_q & ~((wr_en && paddr == `PORS_OFS_INT_STATUS) ?
                pwdata[7:0] : 8'h00)) | irq_src;
            if (wr_en && paddr == `PORS_OFS_CONFIG)
                config_q <= pwdata[2:0];
            if (wr_en && paddr == `PORS_OFS_OFF_RESET_LEVEL)
                off_reset_level_config_q <= pwdata[1:0];
            if (wr_en && paddr == `PORS_OFS_INT_MASK)
                int_mask_q <= pwdata[7:0];
            if (seq_wr && !instr[10])
                res_hw_q[instr[9:8]] <= instr[7:0];
            else if (wr_en && res_hit && !res_idx[2] && in_run)
                res_hw_q[res_idx[1:0]] <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------------------
    // Switch-off domain: device control and resources 4..7
    // ------------------------------------------------------------------------
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            device_on_bit_q <= 1'b0;
            for (j = 0; j < 4; j = j + 1)
                res_swo_q[j] <= 8'h00;
        end
        else if (swo_reset_pulse)
        begin
            device_on_bit_q <= 1'b0;
            for (j = 0; j < 4; j = j + 1)
                res_swo_q[j] <= 8'h00;
        end
        else
        begin
            // The hardware set at sequence end wins over a same-cycle host write.
            if (state_q == ST_SEQ_UP && instr[`PORS_I_END] && config_q[`PORS_CFG_AUTO_ON])
                device_on_bit_q <= 1'b1;
            else if (wr_en && paddr == `PORS_OFS_DEVICE_CONTROL)
                device_on_bit_q <= pwdata[`PORS_DEVCTL_ON];
            if (seq_wr && instr[10])
                res_swo_q[instr[9:8]] <= instr[7:0];
            else if (wr_en && res_hit && res_idx[2] && in_run)
                res_swo_q[res_idx[1:0]] <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------------------
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            reset_out <= 1'b0;
            int_n <= 1'b1;
            power_state <= ST_OFF;
        end
        else
        begin
            reset_out <= in_run;
            int_n <= ~((|(int_status_q & ~int_mask_q)) &&
                       !(state_q == ST_SLEEP && config_q[`PORS_CFG_INT_SLEEP_MASK]));
            power_state <= state_q;
        end
    end

endmodule // pors_top
`default_nettype wire

// >>> pors_checker.sv
// Purpose: Concurrent checks on the ports of pors_top.
// Assumes: power_state codes are 0 off, 1 up, 2 active, 3 sleep, 4 down.
// Notes: Interrupt masking hangs on register contents, so the bench checks it.
`timescale 1ns/10ps
`default_nettype none
`include "pors_consts.vh"
module pors_checker
#(
    parameter LF_DIV = `PORS_LF_DIV,
    parameter HOLD_TICKS = `PORS_HOLD_TICKS
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pslverr,
    input wire logic on_request,
    input wire logic hold_on_pin,
    input wire logic reset_out,
    input wire logic [1:0] reset_level,
    input wire logic hw_reset_pulse,
    input wire logic swo_reset_pulse,
    input wire logic [2:0] power_state
);
    // ----------
    // Properties
    // ----------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // Cycles spent released without acknowledge; bounds the hold window.
    logic [31:0] unack_q;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            unack_q <= 32'h0;
        else if (reset_out && !hold_on_pin)
            unack_q <= unack_q + 32'h1;
        else
            unack_q <= 32'h0;
    end
    sequence s_on_taken;
        power_state == 3'd0 && on_request;
    endsequence
    sequence s_ack_dropped;
        $fell(hold_on_pin) && power_state == 3'd2;
    endsequence
    slverr_phase_a: assert property (pslverr |-> psel && penable)
        else $error("slave error outside access phase");
    reset_hold_a: assert property (reset_out |-> power_state > 3'd1)
        else $error("reset released before sequence end");
    on_start_a: assert property (s_on_taken |-> ##[1:3] power_state == 3'd1)
        else $error("on request did not start the up sequence");
    pulse_single_a: assert property (swo_reset_pulse |=> !swo_reset_pulse)
        else $error("reset pulse longer than one cycle");
    hw_with_swo_a: assert property (hw_reset_pulse |-> swo_reset_pulse)
        else $error("hardware reset without switch-off reset");
    hw_level_a: assert property (hw_reset_pulse |-> ##[0:1] reset_level == 2'h1)
        else $error("hardware reset level code wrong");
    reset_off_a: assert property (swo_reset_pulse |-> !reset_out)
        else $error("domain reset while system reset released");
    hold_fall_a: assert property (s_ack_dropped |-> ##[1:4] power_state == 3'd4)
        else $error("hold pin fall did not start power down");
    window_a: assert property (unack_q <= LF_DIV * HOLD_TICKS + LF_DIV + 8)
        else $error("hold window overran");
endmodule // pors_checker
bind pors_top pors_checker #(.LF_DIV(LF_DIV), .HOLD_TICKS(HOLD_TICKS)) chk_u (.clk(clk),
    .resetn(resetn), .psel(psel), .penable(penable), .pslverr(pslverr),
    .on_request(on_request), .hold_on_pin(hold_on_pin), .reset_out(reset_out),
    .reset_level(reset_level), .hw_reset_pulse(hw_reset_pulse),
    .swo_reset_pulse(swo_reset_pulse), .power_state(power_state));
`default_nettype wire

// >>> pors_host_model.sv
// Purpose: Host processor model that acknowledges power-on on the hold pin.
// Assumes: ACK_DELAY sits well inside the hold window.
// Notes: The pin is push-pull, so it never floats.
`timescale 1ns/10ps
`default_nettype none
module pors_host_model
#(
    parameter int ACK_DELAY = 5
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic reset_out,
    input wire logic ack_en,
    input wire logic drop,
    output logic hold_on_pin
);
    // ----------
    // Acknowledge
    // ----------
    int cnt;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            hold_on_pin <= 1'b0;
            cnt <= 0;
        end
        else if (drop)
            hold_on_pin <= 1'b0;
        else if (ack_en && reset_out && !hold_on_pin)
        begin
            cnt <= cnt + 1;
            if (cnt == ACK_DELAY)
                hold_on_pin <= 1'b1;
        end
        else
            cnt <= 0;
    end
endmodule // pors_host_model
`default_nettype wire

// >>> pors_tb.sv
// Purpose: Self-checking bench for pors_top.
// Assumes: Hold window shortened to 8 ticks of 4 clocks.
// Notes: A second reset mid-run checks the power-on domain.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    // ----------
    // Bench
    // ----------
    logic clk, resetn, psel, penable, pwrite, on_request, boot_sel, sleep_req;
    logic ack_en, drop, pready, pslverr, hold_on_pin, reset_out, int_n, rerr;
    logic hw_reset_pulse, swo_reset_pulse;
    logic [7:0] paddr, irq_src;
    logic [31:0] pwdata, prdata, rdat;
    logic [1:0] reset_level;
    logic [2:0] power_state;
    int error_cnt, checks, n;
    pors_top #(.LF_DIV(4), .HOLD_TICKS(8)) dut_u (.clk(clk), .resetn(resetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .on_request(on_request), .hold_on_pin(hold_on_pin),
        .boot_sel(boot_sel), .sleep_req(sleep_req), .irq_src(irq_src), .reset_out(reset_out),
        .int_n(int_n), .reset_level(reset_level), .hw_reset_pulse(hw_reset_pulse),
        .swo_reset_pulse(swo_reset_pulse), .power_state(power_state));
    pors_host_model host_u (.clk(clk), .resetn(resetn), .reset_out(reset_out),
        .ack_en(ack_en), .drop(drop), .hold_on_pin(hold_on_pin));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task test_done;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task hang;
        error_cnt++;
        test_done;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task ck1(input string nm, input logic s, input logic e);
        chk(nm, {31'h0, s}, {31'h0, e});
    endtask
    // Request is held from setup until pready is sampled high.
    task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
            hang;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask
    task rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(a, 1'b0, 32'h0);
        chk(nm, rdat, e);
    endtask
    task wait_st(input logic [2:0] s);
        int k;
        k = 0;
        while (power_state !== s && k < 300)
        begin
            @(posedge clk);
            k++;
        end
        if (power_state !== s)
            hang;
    endtask
    task up(input logic bs, input logic ack);
        @(posedge clk);
        boot_sel <= bs;
        ack_en <= ack;
        drop <= 1'b0;
        on_request <= 1'b1;
        @(posedge clk);
        on_request <= 1'b0;
        wait_st(3'd2);
        repeat (2) @(posedge clk);
        ck1("reset_out", reset_out, 1'b1);
    endtask
    task down;
        @(posedge clk);
        drop <= 1'b1;
        wait_st(3'd0);
        repeat (2) @(posedge clk);
    endtask
    task irq(input logic [7:0] v);
        @(posedge clk);
        irq_src <= v;
        @(posedge clk);
        irq_src <= 8'h00;
        repeat (3) @(posedge clk);
    endtask
    initial
    begin
        {resetn, psel, penable, pwrite, on_request, boot_sel, sleep_req, ack_en, drop} = 9'h0;
        paddr = 8'h00;
        irq_src = 8'h00;
        pwdata = 32'h0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        rd("config", 8'h04, 32'h6);
        rd("off_level", 8'h08, 32'h3);
        apb(8'h30, 1'b0, 32'h0);
        ck1("pslverr", rerr, 1'b1);
        ck1("int_n", int_n, 1'b1);
        $display("test reset values done");
        up(1'b1, 1'b1);
        rd("boot", 8'h14, 32'h1);
        rd("branch", 8'h44, 32'h42);
        wr(8'h40, 32'ha5);
        rd("resource", 8'h40, 32'ha5);
        wr(8'h1c, 32'h5);
        wr(8'h10, 32'hf);
        repeat (60) @(posedge clk);
        chk("held", {29'h0, power_state}, 32'h2);
        down;
        rd("cause", 8'h18, 32'h1);
        chk("level", {30'h0, reset_level}, 32'h1);
        rd("mask", 8'h10, 32'h0);
        rd("pgood", 8'h1c, 32'h5);
        wr(8'h18, 32'h1);
        $display("test hold pin done");
        wr(8'h08, 32'h0);
        wr(8'h10, 32'hf);
        up(1'b0, 1'b1);
        rd("boot", 8'h14, 32'h0);
        wr(8'h00, 32'h1);
        down;
        chk("level", {30'h0, reset_level}, 32'h2);
        rd("mask", 8'h10, 32'hf);
        rd("devctl", 8'h00, 32'h0);
        wr(8'h18, 32'h1);
        $display("test switch-off reset done");
        up(1'b0, 1'b0);
        n = 0;
        while (reset_out === 1'b1 && n < 300)
        begin
            @(posedge clk);
            n++;
        end
        ck1("window", n >= 26 && n <= 44, 1'b1);
        wait_st(3'd0);
        rd("cause", 8'h18, 32'h2);
        wr(8'h18, 32'h3);
        $display("test timeout done");
        wr(8'h04, 32'h5);
        up(1'b0, 1'b1);
        wr(8'h00, 32'h1);
        repeat (60) @(posedge clk);
        chk("held", {29'h0, power_state}, 32'h2);
        irq(8'h01);
        ck1("int_n", int_n, 1'b1);
        irq(8'h10);
        ck1("int_n", int_n, 1'b0);
        rd("status", 8'h0c, 32'h11);
        wr(8'h0c, 32'h11);
        repeat (3) @(posedge clk);
        ck1("int_n", int_n, 1'b1);
        sleep_req <= 1'b1;
        wait_st(3'd3);
        irq(8'h20);
        ck1("int_n", int_n, 1'b1);
        sleep_req <= 1'b0;
        wait_st(3'd2);
        repeat (3) @(posedge clk);
        ck1("int_n", int_n, 1'b0);
        wr(8'h0c, 32'h20);
        wr(8'h00, 32'h0);
        wait_st(3'd0);
        $display("test register mode done");
        wr(8'h04, 32'h3);
        up(1'b1, 1'b1);
        rd("devctl", 8'h00, 32'h1);
        repeat (60) @(posedge clk);
        chk("held", {29'h0, power_state}, 32'h2);
        wr(8'h00, 32'h0);
        wait_st(3'd0);
        $display("test auto mode done");
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd("pgood", 8'h1c, 32'h0);
        rd("mask", 8'h10, 32'h0);
        $display("test power-on reset done");
        test_done;
    end
endmodule // testbench
`default_nettype wire
